// *** hdl/lsc_cfg.svh ***
// constants of the logic cluster: counts, register map, field positions
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

`define LSC_SLICES      4
`define LSC_GENS        8
`define LSC_TBL_W       16
`define LSC_TBL_RST     16'h0000
`define LSC_SEL_W       4
`define LSC_SYNC_W      54
`define LSC_GEN_INS     32
`define LSC_ADR_W       6
`define LSC_IDX_W       4

// word indices, byte address is four times the index
`define LSC_IDX_TABLE0  4'h0
`define LSC_IDX_CFG0    4'h4
`define LSC_IDX_CTRL    4'h8
`define LSC_IDX_STAT    4'h9

// slice configuration word
`define LSC_CFG_W       21
`define LSC_CFG_RST     21'h000000
`define LSC_B_MODEA     0
`define LSC_B_MODEB     2
`define LSC_B_LATCH     4
`define LSC_B_HIGH      5
`define LSC_B_INITOV    6
`define LSC_B_INITA     7
`define LSC_B_INITB     8
`define LSC_B_ASYNC     9
`define LSC_B_SRCA      10
`define LSC_B_SRCB      11
`define LSC_B_CEUSE     12
`define LSC_B_SRUSE     13
`define LSC_B_BYUSE     14
`define LSC_B_INVCLK    15
`define LSC_B_INVCE     16
`define LSC_B_INVSR     17
`define LSC_B_INVBY     18
`define LSC_B_XF5       19
`define LSC_B_YFX       20

`define LSC_B_GINIT     0
`define LSC_ZERO32      32'h00000000
`define LSC_ZERO16      16'h0000

`endif

// *** hdl/lsc_func_gen.sv ***
// one four-input function generator: table, distributed memory or shift register
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"

module lsc_func_gen (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire lsc_pkg::lsc_gen_mode_type mode_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic                      load_i,
    input  wire logic [`LSC_TBL_W-1:0]     load_val_i,
    input  wire logic                      step_i,
    input  wire logic                      we_i,
    input  wire logic                      din_i,
    input  wire logic                      shift_in_i,
    output logic      [`LSC_TBL_W-1:0]     table_o,
    output logic                           out_o,
    output logic                           shift_out_o
);

    logic [`LSC_TBL_W-1:0] table_d;
    logic [`LSC_TBL_W-1:0] table_q;

    always_comb
    begin
        table_d = table_q;
        case (mode_i)
            lsc_pkg::LSC_GEN_RAM:
            begin
                if (step_i && we_i)
                begin
                    table_d[sel_i] = din_i;   // see R3
                end
            end
            lsc_pkg::LSC_GEN_SHIFT:
            begin
                if (step_i)
                begin
                    table_d = {table_q[`LSC_TBL_W-2:0], shift_in_i};   // see R3
                end
            end
            default:
            begin
                table_d = table_q;
            end
        endcase
        if (load_i)
        begin
            table_d = load_val_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_q <= `LSC_TBL_RST;
        end
        else
        begin
            table_q <= table_d;
        end
    end

    assign table_o     = table_q;
    assign out_o       = table_q[sel_i];   // see R4
    assign shift_out_o = table_q[`LSC_TBL_W-1];

endmodule

`default_nettype wire

// *** hdl/lsc_logic_cluster.sv ***
// logic cluster of four slices with its register port
//
// Overview of operation
// R1 - cluster holds four identical slices
// R2 - slice: two generators, two storage elements
// R3 - generator is table, memory or shifter
// R4 - table gives any four-input function
// R5 - generator feeds output and storage together
// R6 - five-input combiner merges slice generators
// R7 - wide combiner width depends on position
// R8 - storage is flip-flop or latch
// R9 - storage data from generator or bypass
// R10 - enable active high, unused means enabled
// R11 - primary set/reset forces configured level
// R12 - bypass forces opposite; reset wins
// R13 - initial value separately configurable
// R14 - set/reset synchronous or asynchronous
// R15 - clock, enable, set/reset shared per slice
// R16 - every control input has selectable polarity
// R17 - latch transparent at active clock level
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"

module lsc_logic_cluster (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`LSC_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic [`LSC_GEN_INS-1:0] gen_in_i,
    input  wire logic [3:0]              first_bypass_input_i,
    input  wire logic [3:0]              second_bypass_input_i,
    input  wire logic [3:0]              slice_clk_i,
    input  wire logic [3:0]              slice_ce_i,
    input  wire logic [3:0]              primary_set_reset_i,
    input  wire logic                    shift_chain_i,
    input  wire logic                    eight_other_i,
    output logic      [7:0]              comb_out_o,
    output logic      [7:0]              store_q_o,
    output logic                         shift_chain_o,
    output logic                         seven_out_o
);

    // =====================================================
    // pin synchronisers
    // =====================================================
    logic [`LSC_SYNC_W-1:0] pin_raw;
    logic [`LSC_SYNC_W-1:0] meta_q;
    logic [`LSC_SYNC_W-1:0] pin_q;
    logic [`LSC_GEN_INS-1:0] gi;
    logic [3:0]             fb;
    logic [3:0]             sb;
    logic [3:0]             sck;
    logic [3:0]             sce;
    logic [3:0]             ssr;
    logic                   shin;
    logic                   oth;

    assign pin_raw = {eight_other_i, shift_chain_i, primary_set_reset_i, slice_ce_i,
                      slice_clk_i, second_bypass_input_i, first_bypass_input_i, gen_in_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            pin_q  <= '0;
        end
        else
        begin
            meta_q <= pin_raw;
            pin_q  <= meta_q;
        end
    end

    assign {oth, shin, ssr, sce, sck, sb, fb, gi} = pin_q;

    // =====================================================
    // register port
    // =====================================================
    logic [`LSC_IDX_W-1:0] idx;
    logic                  acc;
    logic                  wr;
    logic                  ack_d;
    logic                  ack_q;
    logic [31:0]           dat_d;
    logic [31:0]           dat_q;
    logic                  ginit_d;
    logic                  ginit_q;
    logic [`LSC_CFG_W-1:0] cfg_d [`LSC_SLICES];
    logic [`LSC_CFG_W-1:0] cfg_q [`LSC_SLICES];
    logic [31:0]           tbl_word [`LSC_SLICES];
    logic [31:0]           tbl_new [`LSC_SLICES];
    logic [`LSC_SLICES-1:0] tbl_load;
    logic [7:0]            comb_q;
    logic [7:0]            q_all;

    function automatic logic [31:0] lsc_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign idx = wb_adr_i[`LSC_ADR_W-1:2];
    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr  = acc && wb_we_i;

    always_comb
    begin
        ack_d   = acc;
        ginit_d = wr && (idx == `LSC_IDX_CTRL) && wb_sel_i[0] && wb_dat_i[`LSC_B_GINIT];
        dat_d   = dat_q;
        if (acc)
        begin
            dat_d = `LSC_ZERO32;
        end
        if (acc && !wb_we_i)
        begin
            if (idx == `LSC_IDX_STAT)
            begin
                dat_d = {`LSC_ZERO16, comb_q, q_all};
            end
            for (int s = 0; s < `LSC_SLICES; s++)
            begin
                if (idx == `LSC_IDX_TABLE0 + s[`LSC_IDX_W-1:0])
                begin
                    dat_d = tbl_word[s];
                end
                if (idx == `LSC_IDX_CFG0 + s[`LSC_IDX_W-1:0])
                begin
                    dat_d = 32'(cfg_q[s]);
                end
            end
        end
        for (int s = 0; s < `LSC_SLICES; s++)
        begin
            cfg_d[s]    = cfg_q[s];
            tbl_load[s] = wr && (idx == `LSC_IDX_TABLE0 + s[`LSC_IDX_W-1:0]);
            tbl_new[s]  = lsc_merge(tbl_word[s], wb_dat_i, wb_sel_i);
            if (wr && (idx == `LSC_IDX_CFG0 + s[`LSC_IDX_W-1:0]))
            begin
                cfg_d[s] = `LSC_CFG_W'(lsc_merge(32'(cfg_q[s]), wb_dat_i, wb_sel_i));
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q   <= 1'b0;
            dat_q   <= `LSC_ZERO32;
            ginit_q <= 1'b0;
            for (int s = 0; s < `LSC_SLICES; s++)
            begin
                cfg_q[s] <= `LSC_CFG_RST;
            end
        end
        else
        begin
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            ginit_q <= ginit_d;
            for (int s = 0; s < `LSC_SLICES; s++)
            begin
                cfg_q[s] <= cfg_d[s];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // =====================================================
    // slices
    // =====================================================
    logic [7:0]  gout;
    logic [8:0]  sh;
    logic [3:0]  f5;
    logic [3:0]  fx;
    logic [7:0]  comb_d;
    logic [3:0]  clk_lv;
    logic [3:0]  clk_lv_q;   // raw pin level: a polarity write is no edge
    logic        out7_q;

    assign sh[0] = shin;

    genvar s;
    generate
        for (s = 0; s < `LSC_SLICES; s++)
        begin : g_slice
            logic [`LSC_CFG_W-1:0] c;
            logic edge_s;
            logic ce;
            logic sr;
            logic by;
            logic sr_act;
            logic by_act;
            logic step;
            logic [1:0] dsel;
            logic [1:0] ival;

            assign c      = cfg_q[s];
            assign clk_lv[s] = sck[s] ^ c[`LSC_B_INVCLK];   // see R16
            assign edge_s = clk_lv[s] && !(clk_lv_q[s] ^ c[`LSC_B_INVCLK]);   // see R16
            assign ce     = c[`LSC_B_CEUSE] ? (sce[s] ^ c[`LSC_B_INVCE]) : 1'b1;   // see R10, R16
            assign sr     = ssr[s] ^ c[`LSC_B_INVSR];   // see R16
            assign by     = sb[s] ^ c[`LSC_B_INVBY];   // see R16
            assign sr_act = c[`LSC_B_SRUSE] && sr;
            assign by_act = c[`LSC_B_SRUSE] && c[`LSC_B_BYUSE] && by;   // see R12
            assign step   = edge_s && ce;
            // storage data from the bypass input when the source bit is set, else from the generator or combiner output
            assign dsel   = {c[`LSC_B_SRCB] ? sb[s] : comb_d[2*s+1],
                             c[`LSC_B_SRCA] ? fb[s] : comb_d[2*s]};   // see R5, R9
            assign ival   = c[`LSC_B_INITOV] ? {c[`LSC_B_INITB], c[`LSC_B_INITA]}
                                             : {2{c[`LSC_B_HIGH]}};   // see R13

            lsc_func_gen u_gen_a (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .mode_i      (lsc_pkg::lsc_gen_mode_type'(c[`LSC_B_MODEA +: 2])),
                .sel_i       (gi[8*s +: 4]),
                .load_i      (tbl_load[s] && (wb_sel_i[0] || wb_sel_i[1])),
                .load_val_i  (tbl_new[s][`LSC_TBL_W-1:0]),
                .step_i      (step),
                .we_i        (sr),
                .din_i       (fb[s]),
                .shift_in_i  (sh[2*s]),
                .table_o     (tbl_word[s][`LSC_TBL_W-1:0]),
                .out_o       (gout[2*s]),
                .shift_out_o (sh[2*s+1])
            );   // see R2, R3

            lsc_func_gen u_gen_b (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .mode_i      (lsc_pkg::lsc_gen_mode_type'(c[`LSC_B_MODEB +: 2])),
                .sel_i       (gi[8*s+4 +: 4]),
                .load_i      (tbl_load[s] && (wb_sel_i[2] || wb_sel_i[3])),
                .load_val_i  (tbl_new[s][31:`LSC_TBL_W]),
                .step_i      (step),
                .we_i        (sr),
                .din_i       (sb[s]),
                .shift_in_i  (sh[2*s+1]),
                .table_o     (tbl_word[s][31:`LSC_TBL_W]),
                .out_o       (gout[2*s+1]),
                .shift_out_o (sh[2*s+2])
            );   // see R1, R2

            assign f5[s] = fb[s] ? gout[2*s+1] : gout[2*s];   // see R6
            assign comb_d[2*s]   = c[`LSC_B_XF5] ? f5[s] : gout[2*s];   // see R5
            assign comb_d[2*s+1] = c[`LSC_B_YFX] ? fx[s] : gout[2*s+1];

            lsc_store_pair u_store (
                .clk_i      (clk_i),
                .init_i     (rst_i || ginit_q),
                .init_val_i (ival),
                .latch_i    (c[`LSC_B_LATCH]),
                .async_i    (c[`LSC_B_ASYNC]),
                .edge_i     (edge_s),
                .level_i    (clk_lv[s]),
                .ce_i       (ce),
                .rst_cond_i (c[`LSC_B_HIGH] ? by_act : sr_act),   // see R11, R12
                .set_cond_i (c[`LSC_B_HIGH] ? sr_act : by_act),
                .d_i        (dsel),
                .q_o        (q_all[2*s +: 2])
            );   // see R15
        end
    endgenerate

    // wide combiners: six in slices 0 and 2, seven in 1, eight in 3
    assign fx[0] = sb[0] ? f5[1] : f5[0];   // see R7
    assign fx[2] = sb[2] ? f5[3] : f5[2];   // see R7
    assign fx[1] = sb[1] ? fx[2] : fx[0];   // see R7
    assign fx[3] = sb[3] ? oth : fx[1];     // see R7

    // =====================================================
    // output registers
    // =====================================================
    always_ff @(posedge clk_i)
    begin
        clk_lv_q <= sck;
        if (rst_i)
        begin
            comb_q <= 8'h00;
            out7_q <= 1'b0;
        end
        else
        begin
            comb_q <= comb_d;
            out7_q <= fx[1];
        end
    end

    assign comb_out_o    = comb_q;
    assign store_q_o     = q_all;
    assign shift_chain_o = sh[`LSC_GENS];
    assign seven_out_o   = out7_q;

endmodule

`default_nettype wire

// *** hdl/lsc_pkg.sv ***
// types shared by the logic cluster modules
package lsc_pkg;

    typedef enum logic [1:0] {
        LSC_GEN_LUT   = 2'h0,
        LSC_GEN_RAM   = 2'h1,
        LSC_GEN_SHIFT = 2'h2
    } lsc_gen_mode_type;

endpackage

// *** hdl/lsc_store_pair.sv ***
// the two storage elements of one slice with their shared controls
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"

module lsc_store_pair (
    input  wire logic       clk_i,
    input  wire logic       init_i,
    input  wire logic [1:0] init_val_i,
    input  wire logic       latch_i,
    input  wire logic       async_i,
    input  wire logic       edge_i,
    input  wire logic       level_i,
    input  wire logic       ce_i,
    input  wire logic       rst_cond_i,
    input  wire logic       set_cond_i,
    input  wire logic [1:0] d_i,
    output logic      [1:0] q_o
);

    logic [1:0] q_d;
    logic [1:0] q_q;
    logic       upd;
    logic       sr_take;

    always_comb
    begin
        upd     = latch_i ? (level_i && ce_i) : (edge_i && ce_i);   // see R8, R17
        sr_take = async_i ? 1'b1 : (latch_i ? level_i : edge_i);   // see R14
        q_d     = q_q;
        if (init_i)
        begin
            q_d = init_val_i;   // see R13
        end
        else if (sr_take && rst_cond_i)
        begin
            q_d = 2'h0;   // see R12
        end
        else if (sr_take && set_cond_i)
        begin
            q_d = 2'h3;   // see R11
        end
        else if (upd)
        begin
            q_d = d_i;   // see R15
        end
    end

    always_ff @(posedge clk_i)
    begin
        q_q <= q_d;
    end

    assign q_o = q_q;

endmodule

`default_nettype wire

// *** verif/lsc_logic_cluster_monitor.sv ***
// port checks of the logic cluster, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "lsc_cfg.svh"

module lsc_logic_cluster_monitor (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [`LSC_ADR_W-1:0]   wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire logic [`LSC_GEN_INS-1:0] gen_in_i,
    input wire logic [3:0]              first_bypass_input_i,
    input wire logic [3:0]              second_bypass_input_i,
    input wire logic [3:0]              slice_clk_i,
    input wire logic [3:0]              slice_ce_i,
    input wire logic [3:0]              primary_set_reset_i,
    input wire logic                    shift_chain_i,
    input wire logic                    eight_other_i,
    input wire logic [7:0]              comb_out_o,
    input wire logic [7:0]              store_q_o,
    input wire logic                    shift_chain_o,
    input wire logic                    seven_out_o
);
    // ====================
    // bus steps
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read;
        s_take ##0 !wb_we_i;
    endsequence
    sequence s_quiet;
        ($stable(gen_in_i) && $stable(slice_clk_i) && $stable(first_bypass_input_i)
            && $stable(second_bypass_input_i) && $stable(eight_other_i) && !(wb_cyc_i && wb_stb_i))[*5];
    endsequence

    // ====================
    // checks
    a_ack_follows: assert property (s_take |=> wb_ack_o)
        else $error("no ack after taken request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_write_zero: assert property ((s_take ##0 wb_we_i) |=> wb_dat_o == 32'h0)
        else $error("read data not zero after write");
    a_unmapped_zero: assert property ((s_read ##0 (wb_adr_i[5:2] == 4'h8 || wb_adr_i[5:2] > 4'h9))
        |=> wb_dat_o == 32'h0)
        else $error("unmapped or control read not zero");
    a_cfg_width: assert property ((s_read ##0 wb_adr_i[5:4] == 2'h1) |=> wb_dat_o[31:21] == 11'h0)
        else $error("config read beyond field width");
    a_stat_view: assert property ((s_read ##0 wb_adr_i[5:2] == 4'h9)
        |=> wb_dat_o == {16'h0, $past(comb_out_o), $past(store_q_o)})
        else $error("status read differs from outputs");
    a_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0
        && comb_out_o == 8'h0 && store_q_o == 8'h0)
        else $error("outputs not cleared by reset");
    a_comb_hold: assert property (s_quiet |-> $stable(comb_out_o))
        else $error("generator output moved with quiet inputs");
endmodule

bind lsc_logic_cluster lsc_logic_cluster_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gen_in_i(gen_in_i), .first_bypass_input_i(first_bypass_input_i),
    .second_bypass_input_i(second_bypass_input_i), .slice_clk_i(slice_clk_i), .slice_ce_i(slice_ce_i),
    .primary_set_reset_i(primary_set_reset_i), .shift_chain_i(shift_chain_i),
    .eight_other_i(eight_other_i), .comb_out_o(comb_out_o), .store_q_o(store_q_o),
    .shift_chain_o(shift_chain_o), .seven_out_o(seven_out_o)
);
`default_nettype wire

// *** verif/lsc_logic_cluster_test.sv ***
// self-checking bench of the logic cluster against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module lsc_logic_cluster_test;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [5:0]  wb_adr;
    logic [3:0]  wb_sel, byp_a, byp_b, sclk, sce, psr;
    logic [31:0] wb_wd, wb_rd, gin, rd;
    logic [31:0] tbl [4];
    logic [20:0] cfg [4];
    logic [7:0]  comb, sq, eq;
    logic        shin, oth, sco, s7, x7;
    int          mismatches = 0, cmp_count = 0, cyc_cnt = 0;

    lsc_logic_cluster u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .gen_in_i(gin), .first_bypass_input_i(byp_a), .second_bypass_input_i(byp_b),
        .slice_clk_i(sclk), .slice_ce_i(sce), .primary_set_reset_i(psr), .shift_chain_i(shin),
        .eight_other_i(oth), .comb_out_o(comb), .store_q_o(sq), .shift_chain_o(sco), .seven_out_o(s7)
    );

    always #4 clk_i = ~clk_i;

    // ====================
    // run control
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 10000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    // ====================
    // model and bus
    function automatic logic [7:0] exp_comb();
        logic [7:0] e;
        logic [3:0] f, x;
        for (int s = 0; s < 4; s++)
        begin
            e[2*s] = tbl[s][gin[8*s+:4]];
            e[2*s+1] = tbl[s][16 + gin[8*s+4+:4]];
            f[s] = byp_a[s] ? e[2*s+1] : e[2*s];
        end
        x[0] = byp_b[0] ? f[1] : f[0];
        x[2] = byp_b[2] ? f[3] : f[2];
        x[1] = byp_b[1] ? x[2] : x[0];
        x[3] = byp_b[3] ? oth : x[1];
        x7 = x[1];
        for (int s = 0; s < 4; s++)
            e[2*s+:2] = {cfg[s][20] ? x[s] : e[2*s+1], cfg[s][19] ? f[s] : e[2*s]};
        return e;
    endfunction

    function automatic logic [1:0] nq(int s, logic [1:0] q, logic a);
        logic [20:0] c;
        logic        sr, by, ce;
        logic [7:0]  e;
        c = cfg[s];
        e = exp_comb();
        sr = c[13] & (psr[s] ^ c[17]);
        by = c[13] & c[14] & (byp_b[s] ^ c[18]);
        ce = ~c[12] | (sce[s] ^ c[16]);
        if ((c[9] | a) & (sr | by))
            return {2{(sr & ~by) ? c[5] : (by & ~sr) ? ~c[5] : 1'b0}};
        if (a & ce)
            return {c[11] ? byp_b[s] : e[2*s+1], c[10] ? byp_a[s] : e[2*s]};
        return q;
    endfunction

    task automatic step(input logic [3:0] a);
        for (int s = 0; s < 4; s++)
            eq[2*s+:2] = nq(s, eq[2*s+:2], a[s]);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic pulse;
        sclk <= 4'hF;
        tick(3);
        sclk <= 4'h0;
        tick(3);
    endtask

    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wd, wb_sel} <= {2'b11, w, a, d, s};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rd = wb_rd;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask

    function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] s);
        for (int i = 0; i < 4; i++)
            if (s[i])
                o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction

    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
        bus(6'(i * 4), 1'b1, d, s);
        if (i < 4)
            tbl[i] = mrg(tbl[i], d, s);
        else if (i < 8)
            cfg[i-4] = 21'(mrg(32'(cfg[i-4]), d, s));
    endtask

    task automatic regs_all;
        for (int i = 0; i < 16; i++)
            if (i != 9)
            begin
                bus(6'(i * 4), 1'b0, 32'h0, 4'hF);
                `CHK("register", i < 4 ? tbl[i] : i < 8 ? 32'(cfg[i-4]) : 32'h0, rd)
            end
    endtask

    task automatic doinit;
        wr(8, 32'h1, 4'hF);
        tick(3);
        for (int s = 0; s < 4; s++)
            eq[2*s+:2] = cfg[s][6] ? {cfg[s][8], cfg[s][7]} : {2{cfg[s][5]}};
    endtask

    // ====================
    // scenarios
    initial
    begin
        {clk_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wd} = '0;
        {gin, byp_a, byp_b, sclk, sce, psr, eq, shin, oth} = '0;
        rst_i = 1'b1;
        tbl = '{default: '0};
        cfg = '{default: '0};
        void'($urandom(32'h9389));
        tick(8);
        rst_i <= 1'b0;
        regs_all();
        for (int i = 0; i < 13; i++)
            wr(i, $urandom, 4'($urandom));
        regs_all();
        for (int s = 0; s < 4; s++)
            wr(4 + s, 32'h0, 4'hF);
        doinit();
        for (int k = 0; k < 24; k++)
        begin
            if (k % 6 == 0)
                for (int s = 0; s < 4; s++)
                    wr(s, $urandom, 4'hF);
            if (k == 12)
                for (int s = 0; s < 4; s++)
                    wr(4 + s, 32'h180000, 4'hF);
            {byp_a, byp_b, oth} <= (k < 12) ? 9'h0 : 9'($urandom);
            gin <= $urandom;
            tick(4);
            `CHK("comb", exp_comb(), comb)
            `CHK("seven", x7, s7)
        end
        for (int s = 0; s < 4; s++)
            wr(4 + s, 32'(s & 1) * 32'hC00 | 32'(s >> 1) << 12, 4'hF);
        for (int k = 0; k < 16; k++)
        begin
            {byp_a, byp_b, sce} <= 12'($urandom);
            gin <= $urandom;
            tick(4);
            pulse();
            step(4'hF);
            `CHK("flop", eq, sq)
        end
        for (int s = 0; s < 4; s++)
            wr(4 + s, 32'hA, 4'hF);
        for (int k = 0; k < 6; k++)
        begin
            shin <= 1'($urandom);
            tick(4);
            pulse();
            {tbl[3], tbl[2], tbl[1], tbl[0]} = {tbl[3][30:0], tbl[2], tbl[1], tbl[0], shin};
            `CHK("chain", tbl[3][31], sco)
        end
        regs_all();
        for (int v = 0; v < 16; v++)
        begin
            for (int s = 0; s < 4; s++)
                wr(4 + s, 32'h6000 | 32'(v & 1) << 5 | 32'(v >> 1 & 1) << 9 | 32'(v >> 2) << 17, 4'hF);
            psr <= {4{cfg[0][17]}};
            byp_b <= {4{cfg[0][18]}};
            tick(3);
            doinit();
            for (int p = 0; p < 4; p++)
            begin
                psr <= {4{p[0] ^ cfg[0][17]}};
                byp_b <= {4{p[1] ^ cfg[0][18]}};
                tick(4);
                step(4'h0);
                `CHK("force level", eq, sq)
                pulse();
                step(4'hF);
                `CHK("force edge", eq, sq)
            end
        end
        for (int k = 0; k < 2; k++)
        begin
            for (int s = 0; s < 4; s++)
                wr(4 + s, k ? 32'h160 : 32'h0C0, 4'hF);
            doinit();
            `CHK("init", k ? 8'hAA : 8'h55, sq)
        end
        for (int s = 0; s < 4; s++)
            wr(4 + s, 32'h10 | 32'(s & 1) << 15, 4'hF);
        for (int k = 0; k < 12; k++)
        begin
            gin <= $urandom;
            sclk <= (k == 0) ? 4'h5 : 4'($urandom);
            tick(5);
            step(sclk ^ 4'hA);
            `CHK("latch", eq, sq)
        end
        bus(6'h24, 1'b0, 32'h0, 4'hF);
        `CHK("status", {16'h0, exp_comb(), eq}, rd)
        rst_i <= 1'b1;
        tick(4);
        rst_i <= 1'b0;
        tbl = '{default: '0};
        cfg = '{default: '0};
        regs_all();
        `CHK("reset store", 8'h00, sq)
        report_and_stop();
    end
endmodule
`default_nettype wire
